/* File: design/tprb_pkg.sv */
// transceiver analog-control readback: shared constants and carriers
// assumes one reconfiguration clock domain, no register bus
package tprb_pkg;
   // ---------------------------------------------------------------
   // sizing
   // ---------------------------------------------------------------
   localparam int TPRB_NUM_CH = 4;
   localparam int TPRB_CH_W = $clog2(TPRB_NUM_CH);
   localparam int TPRB_SWING_W = 3;
   localparam int TPRB_EMPH_W = 4;
   localparam int TPRB_EQ_W = 3;
   localparam int TPRB_FETCH_CYC = 4;
   localparam int TPRB_CNT_W = 3;
   localparam logic [TPRB_CNT_W-1:0] TPRB_FETCH_LAST =
      TPRB_CNT_W'(TPRB_FETCH_CYC - 1);
   localparam logic [TPRB_CNT_W-1:0] TPRB_CNT_ZERO = 3'h0;
   // ---------------------------------------------------------------
   // direction select codes
   // ---------------------------------------------------------------
   localparam logic [1:0] TPRB_DIR_RX = 2'h1;
   localparam logic [1:0] TPRB_DIR_TX = 2'h2;
   localparam logic [1:0] TPRB_DIR_DUPLEX = 2'h3;

   typedef struct packed {
      logic [TPRB_SWING_W-1:0] tx_swing;
      logic [TPRB_EMPH_W-1:0] tx_emph;
      logic [TPRB_EQ_W-1:0] rx_eq;
   } tprb_pma_t;

   localparam tprb_pma_t TPRB_PMA_ZERO = '0;

   typedef enum logic [1:0] {
      TPRB_IDLE,
      TPRB_FETCH,
      TPRB_DONE
   } tprb_state_t;
endpackage

/* File: design/tprb_readback.sv */
// read side of the transceiver reconfiguration controller
// assumes requests and channel settings are on core_clk already
//
// Notes on behaviour
// - direction 10 returns transmit controls only
// - busy high while fetching settings
// - busy returns low at completion
// - data valid asserted on completion
// - fetched settings appear on one packed output, pma_out
// - channel select just wide enough
module tprb_readback
   import tprb_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic [TPRB_CH_W-1:0] chan_addr,
   input wire logic [1:0] dir_sel,
   input wire logic rd_req,
   input wire tprb_pma_t chan_pma [TPRB_NUM_CH],
   output logic busy,
   output logic data_valid,
   output tprb_pma_t pma_out
);
   // ---------------------------------------------------------------
   // request capture and sequencing
   // ---------------------------------------------------------------
   tprb_state_t state_q, state_d;
   logic [TPRB_CNT_W-1:0] cnt_q, cnt_d;
   logic [TPRB_CH_W-1:0] ch_q, ch_d;
   logic [1:0] dir_q, dir_d;
   tprb_pma_t out_q, out_d;
   logic valid_q, valid_d;
   logic fetch_last;

   // last fetch cycle: the only edge that may load the result
   assign fetch_last = (state_q == TPRB_FETCH) && (cnt_q == TPRB_FETCH_LAST);

   // masks away the portion the requester did not ask for
   // code 00 is left undecoded and returns both portions, like duplex
   function automatic tprb_pma_t dir_mask(input tprb_pma_t v,
                                          input logic [1:0] d);
      tprb_pma_t r;
      r = v;
      if (d == TPRB_DIR_TX) begin
         r.rx_eq = '0;
      end
      if (d == TPRB_DIR_RX) begin
         r.tx_swing = '0;
         r.tx_emph = '0;
      end
      return r;
   endfunction

   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q;
      ch_d = ch_q;
      dir_d = dir_q;
      out_d = out_q;
      valid_d = valid_q;
      case (state_q)
         TPRB_IDLE: begin
            // request latched here only, so busy-time pulses drop
            if (rd_req) begin
               state_d = TPRB_FETCH;
               cnt_d = TPRB_CNT_ZERO;
               ch_d = chan_addr;
               dir_d = dir_sel;
               valid_d = 1'b0;
            end
         end
         TPRB_FETCH: begin
            if (fetch_last) begin
               state_d = TPRB_DONE;
               out_d = dir_mask(chan_pma[ch_q], dir_q);
            end else begin
               cnt_d = cnt_q + 1'b1;
            end
         end
         TPRB_DONE: begin
            state_d = TPRB_IDLE;
            valid_d = 1'b1;
         end
         default: begin
            state_d = TPRB_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         state_q <= TPRB_IDLE;
         cnt_q <= TPRB_CNT_ZERO;
         ch_q <= '0;
         dir_q <= TPRB_DIR_DUPLEX;
         out_q <= TPRB_PMA_ZERO;
         valid_q <= 1'b0;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         ch_q <= ch_d;
         dir_q <= dir_d;
         out_q <= out_d;
         valid_q <= valid_d;
      end
   end

   assign busy = (state_q != TPRB_IDLE);
   assign data_valid = valid_q;
   assign pma_out = out_q;

   // ---------------------------------------------------------------
   // checks: request handshake
   // ---------------------------------------------------------------
   sequence s_start;
      !busy && rd_req;
   endsequence

   // five busy cycles: four fetch steps, then the done step
   sequence s_fetch;
      busy [*5] ##1 !busy;
   endsequence

   sequence s_busy_req;
      busy && rd_req;
   endsequence

   sequence s_quiet;
      !busy && !rd_req;
   endsequence

   a_busy_on_read: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      s_start |=> busy)
      else $error("busy not raised");

   a_busy_span: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      s_start |=> s_fetch)
      else $error("busy span wrong");

   a_busy_only_req: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      s_quiet |=> !busy)
      else $error("busy without request");

   a_count_start: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      $rose(busy) |-> cnt_q == TPRB_CNT_ZERO)
      else $error("fetch count not cleared");

   a_done_last: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      state_q == TPRB_DONE |=> !busy)
      else $error("busy past done");

   a_ignore_busy: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      s_busy_req |=> $stable(ch_q) && $stable(dir_q))
      else $error("busy request taken");

   // a request in the done cycle must not cancel the result
   a_ignore_valid: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      s_busy_req ##1 !busy |-> data_valid)
      else $error("busy request cut the read");

   a_valid_at_end: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      $fell(busy) |-> data_valid)
      else $error("valid missing");

   a_valid_drop: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      s_start |=> !data_valid)
      else $error("stale valid");

   a_valid_holds: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      data_valid && !rd_req |=> data_valid)
      else $error("valid dropped early");

   a_valid_rise: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      $rose(data_valid) |-> $fell(busy))
      else $error("valid not at completion");

   a_valid_idle: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      data_valid |-> !busy)
      else $error("valid while busy");

   // ---------------------------------------------------------------
   // checks: returned data
   // ---------------------------------------------------------------
   a_tx_only: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      data_valid && dir_q == TPRB_DIR_TX |-> pma_out.rx_eq == '0)
      else $error("rx part returned");

   a_rx_only: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      data_valid && dir_q == TPRB_DIR_RX
         |-> pma_out.tx_swing == '0 && pma_out.tx_emph == '0)
      else $error("tx part returned");

   // settings were sampled on the edge that ended the last fetch cycle
   a_data_match: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      $fell(busy) |-> pma_out == dir_mask($past(chan_pma[ch_q], 2), dir_q))
      else $error("wrong data");

   // only the load edge may move the result
   a_out_stable: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      busy && !fetch_last |=> $stable(pma_out))
      else $error("output moved");

   a_out_idle: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      s_quiet |=> $stable(pma_out))
      else $error("output moved while idle");
endmodule

/* File: testbench/tprb_chan_model.sv */
// channel settings model feeding the readback controller
// assumes gen only moves while the reader is idle
module tprb_chan_model
   import tprb_pkg::*;
(
   input wire logic [1:0] gen,
   output tprb_pma_t chan_pma [TPRB_NUM_CH]
);
   timeunit 1ns;
   timeprecision 100ps;
   // distinct per channel so a wrong address shows
   always_comb begin
      for (int k = 0; k < TPRB_NUM_CH; k++) begin
         chan_pma[k] = {3'(k + gen), 4'(k * 3 + gen), 3'(~k)};
      end
   end
endmodule

/* File: testbench/tprb_readback_bench.sv */
// self-checking bench for the readback controller
// assumes the channel model holds settings steady during reads
module tprb_readback_bench;
   import tprb_pkg::*;
   timeunit 1ns;
   timeprecision 100ps;
   logic core_clk = 1'b0;
   logic rst_b = 1'b0;
   logic [TPRB_CH_W-1:0] chan_addr = '0;
   logic [1:0] dir_sel = 2'h0;
   logic rd_req = 1'b0;
   logic [1:0] gen = 2'h0;
   tprb_pma_t chan_pma [TPRB_NUM_CH];
   logic busy;
   logic data_valid;
   tprb_pma_t pma_out;
   int fails = 0;
   int checked = 0;
   tprb_readback tprb_readback_i (.core_clk(core_clk), .rst_b(rst_b),
      .chan_addr(chan_addr), .dir_sel(dir_sel), .rd_req(rd_req),
      .chan_pma(chan_pma), .busy(busy), .data_valid(data_valid),
      .pma_out(pma_out));
   tprb_chan_model tprb_chan_model_i (.gen(gen), .chan_pma(chan_pma));
   initial begin
      forever #10 core_clk = ~core_clk;
   end
   task automatic chk(input string n, input logic [9:0] s,
                      input logic [9:0] x);
      checked++;
      if (s !== x) begin
         fails++;
         $display("ERROR %s expected %h seen %h", n, x, s);
      end
   endtask
   task automatic close_out;
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   function automatic tprb_pma_t expv(int ch, logic [1:0] d);
      tprb_pma_t p;
      p = {3'(ch + gen), 4'(ch * 3 + gen), 3'(~ch)};
      if (d == TPRB_DIR_TX) p.rx_eq = '0;
      if (d == TPRB_DIR_RX) p[9:3] = '0;
      return p;
   endfunction
   // ----------------------------------------------------------------
   // one read; poke fires extra requests mid-fetch and in the done cycle
   // ----------------------------------------------------------------
   task automatic rd(input int ch, input logic [1:0] d, input bit poke);
      int n;
      n = 0;
      while (busy !== 1'b0) begin
         @(posedge core_clk);
         #1 n++;
         if (n > 20) begin
            fails++;
            close_out();
         end
      end
      chan_addr = TPRB_CH_W'(ch);
      dir_sel = d;
      rd_req = 1'b1;
      @(posedge core_clk);
      #1 rd_req = 1'b0;
      n = 0;
      chk("valid_drop", 10'(data_valid), 10'h0);
      // a poke lands once mid-fetch and once in the done cycle
      while (busy === 1'b1 && n < 20) begin
         if ((n == 2 || n == 4) && poke) begin
            rd_req = 1'b1;
            chan_addr = chan_addr + 1'b1;
         end
         @(posedge core_clk);
         #1 n++;
         if (rd_req) rd_req = 1'b0;
      end
      chk("busy_len", 10'(n), 10'h5);
      chk("valid", 10'(data_valid), 10'h1);
      chk("pma", pma_out, expv(ch, d));
      // the done-cycle poke was cleared this step: let an edge pass
      if (poke) begin
         @(posedge core_clk);
         #1;
      end
   endtask
   initial begin
      repeat (6) @(posedge core_clk);
      chk("rst_pma", pma_out, 10'h0);
      #1 rst_b = 1'b1;
      for (int c = 0; c < TPRB_NUM_CH; c++) begin
         gen = 2'(c);
         rd(c, TPRB_DIR_TX, 1'b0);
      end
      $display("test channels done");
      rd(3, TPRB_DIR_RX, 1'b1);
      rd(1, TPRB_DIR_DUPLEX, 1'b1);
      rd(2, 2'h0, 1'b0);
      $display("test directions done");
      // reset in mid-fetch must drop busy and clear the result
      rd_req = 1'b1;
      @(posedge core_clk);
      #1 rd_req = 1'b0;
      @(posedge core_clk);
      #1 rst_b = 1'b0;
      #1 chk("rst_busy", 10'(busy), 10'h0);
      chk("rst_valid", 10'(data_valid), 10'h0);
      chk("rst_out", pma_out, 10'h0);
      @(posedge core_clk);
      #1 rst_b = 1'b1;
      rd(1, TPRB_DIR_TX, 1'b0);
      $display("test reset done");
      close_out();
   end
endmodule
